// ===== logic/plm_pkg.sv
// Package for the loop mode register bank: address map, codes, reset values.
// Assumes register numbers arrive as plain 16-bit binary values.
package plm_pkg;
  localparam int unsigned NUM_LOOPS = 8;
  localparam logic [15:0] ADDR_BASE = 16'h3A98;
  localparam logic [15:0] LOOP_STRIDE = 16'h0064;
  localparam logic [15:0] OFF_AM_SEL = 16'h0000;
  localparam logic [15:0] OFF_SP_SEL = 16'h0001;
  localparam logic [15:0] OFF_TUNE_SEL = 16'h0002;
  localparam logic [15:0] OFF_DUAL_AM_SEL = 16'h0003;
  localparam logic [15:0] OFF_DUAL_SP_SEL = 16'h0004;
  localparam logic [15:0] OFF_PRESS_TUNE_SEL = 16'h0005;
  localparam logic [15:0] OFF_FLOW_TUNE_SEL = 16'h0006;
  localparam logic [15:0] OFF_DIR_SEL = 16'h0007;
  localparam logic [15:0] OFF_ACTIVITY = 16'h0008;
  localparam logic [15:0] OFF_CFG_TYPE = 16'h0009;
  localparam logic [15:0] OFF_TASK_TYPE = 16'h000A;
  localparam logic [15:0] OFF_AM_STATE = 16'h000B;
  localparam logic [15:0] OFF_SP_STATE = 16'h000C;
  localparam logic [15:0] OFF_TUNE_STATE = 16'h000D;
  localparam logic [15:0] OFF_ERR_STATUS = 16'h000E;
  localparam logic [15:0] OFF_MAN_HI = 16'h0018;
  localparam logic [15:0] OFF_MAN_LO = 16'h0019;
  localparam logic [1:0] CODE_ONE = 2'h1;
  localparam logic [1:0] CODE_TWO = 2'h2;
  localparam logic [1:0] CODE_RESET = 2'h1;
  localparam int unsigned ERR_NONE_BIT = 0;
  localparam int unsigned ERR_PV_BIT = 1;
  localparam int unsigned ERR_SP_BIT = 2;
  typedef logic [7:0][1:0] plm_code_t;
  typedef struct packed {
    plm_code_t am;
    plm_code_t sp;
    plm_code_t tune;
    plm_code_t dam;
    plm_code_t dsp;
    plm_code_t ptune;
    plm_code_t ftune;
    plm_code_t dir;
    logic [7:0][15:0] man_hi;
    logic [7:0][31:0] man_val;
    logic [15:0] rdata;
    logic ack;
    logic err;
    logic mo_valid;
    logic [31:0] mo_data;
    logic [2:0] mo_loop;
  } plm_state_s;
endpackage : plm_pkg

// ===== logic/plm_regbank.sv
// Loop mode register bank for eight control loops, one access port.
// Assumes one-cycle read/write strobes synchronous to core_clk.
`timescale 1ns/100ps
module plm_regbank (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  input wire logic [7:0] loop_active,
  input wire logic [15:0] loop_type_code,
  input wire logic [7:0] task_outlet_max,
  input wire logic [7:0] pv_invalid,
  input wire logic [7:0] sp_invalid,
  output logic [7:0] single_manual,
  output logic [7:0] single_remote_setpoint,
  output logic [7:0] single_second_tuning_set,
  output logic [7:0] dual_manual,
  output logic [7:0] dual_remote_setpoint,
  output logic [7:0] pressure_loop_second_tuning_set,
  output logic [7:0] flow_loop_second_tuning_set,
  output logic [7:0] flow_negative,
  output logic manual_out_valid,
  output logic [31:0] manual_out_data,
  output logic [2:0] manual_out_loop
);

  plm_pkg::plm_state_s s_r;
  plm_pkg::plm_state_s s_nxt;

  logic hit;
  logic [2:0] idx;
  logic [15:0] off;
  logic [15:0] rel;
  logic access;
  logic code_ok;
  logic [1:0] type_sel;
  logic [2:0] err_sel;
  logic [31:0] man_new;
  logic [1:0] act_code;
  logic [1:0] task_code;
  logic wr_one;
  logic wr_two;
  logic rd_hit;

  assign access = reg_wr | reg_rd;
  assign code_ok = (reg_wdata == {14'h0000, plm_pkg::CODE_ONE}) ||
                   (reg_wdata == {14'h0000, plm_pkg::CODE_TWO});
  // Qualifiers shared by the checks below
  assign wr_one = reg_wr && hit && (reg_wdata == {14'h0000, plm_pkg::CODE_ONE});
  assign wr_two = reg_wr && hit && (reg_wdata == {14'h0000, plm_pkg::CODE_TWO});
  assign rd_hit = reg_rd && !reg_wr && hit;

  // Both conventions share this decode, so no convention input is needed
  always_comb begin
    rel = reg_addr - plm_pkg::ADDR_BASE;
    hit = 1'b0;
    idx = 3'h0;
    off = 16'h0000;
    if (reg_addr >= plm_pkg::ADDR_BASE) begin
      for (int k = 1; k <= plm_pkg::NUM_LOOPS; k++) begin
        if (rel >= 16'(k * 100) && rel < 16'(k * 100 + 100)) begin
          hit = 1'b1;
          idx = 3'(k - 1);
          off = rel - 16'(k * 100);
        end
      end
    end
  end

  always_comb begin
    type_sel = loop_type_code[idx*2 +: 2];
    // No-error flag is derived, never stored, so it cannot disagree
    err_sel = {sp_invalid[idx], pv_invalid[idx], ~(sp_invalid[idx] | pv_invalid[idx])};
    man_new = {s_r.man_hi[idx], reg_wdata};
    act_code = loop_active[idx] ? plm_pkg::CODE_ONE : plm_pkg::CODE_TWO;
    task_code = task_outlet_max[idx] ? plm_pkg::CODE_ONE : plm_pkg::CODE_TWO;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.mo_valid = 1'b0;
    if (access) begin
      s_nxt.ack = 1'b1;
      s_nxt.err = ~hit;
    end
    if (reg_wr && hit) begin
      case (off)
        plm_pkg::OFF_AM_SEL: if (code_ok) s_nxt.am[idx] = reg_wdata[1:0];
        plm_pkg::OFF_SP_SEL: if (code_ok) s_nxt.sp[idx] = reg_wdata[1:0];
        plm_pkg::OFF_TUNE_SEL: if (code_ok) s_nxt.tune[idx] = reg_wdata[1:0];
        plm_pkg::OFF_DUAL_AM_SEL: if (code_ok) s_nxt.dam[idx] = reg_wdata[1:0];
        plm_pkg::OFF_DUAL_SP_SEL: if (code_ok) s_nxt.dsp[idx] = reg_wdata[1:0];
        plm_pkg::OFF_PRESS_TUNE_SEL: if (code_ok) s_nxt.ptune[idx] = reg_wdata[1:0];
        plm_pkg::OFF_FLOW_TUNE_SEL: if (code_ok) s_nxt.ftune[idx] = reg_wdata[1:0];
        plm_pkg::OFF_DIR_SEL: if (code_ok) s_nxt.dir[idx] = reg_wdata[1:0];
        plm_pkg::OFF_MAN_HI: s_nxt.man_hi[idx] = reg_wdata;
        plm_pkg::OFF_MAN_LO: begin
          s_nxt.man_val[idx] = man_new;
          // Rewriting the same value must not retrigger the output path
          if (man_new != s_r.man_val[idx]) begin
            s_nxt.mo_valid = 1'b1;
            s_nxt.mo_data = man_new;
            s_nxt.mo_loop = idx;
          end
        end
        default: begin
          s_nxt.err = 1'b0;
        end
      endcase
    end else if (reg_rd && hit) begin
      case (off)
        plm_pkg::OFF_AM_SEL: s_nxt.rdata = {14'h0000, s_r.am[idx]};
        plm_pkg::OFF_SP_SEL: s_nxt.rdata = {14'h0000, s_r.sp[idx]};
        plm_pkg::OFF_TUNE_SEL: s_nxt.rdata = {14'h0000, s_r.tune[idx]};
        plm_pkg::OFF_DUAL_AM_SEL: s_nxt.rdata = {14'h0000, s_r.dam[idx]};
        plm_pkg::OFF_DUAL_SP_SEL: s_nxt.rdata = {14'h0000, s_r.dsp[idx]};
        plm_pkg::OFF_PRESS_TUNE_SEL: s_nxt.rdata = {14'h0000, s_r.ptune[idx]};
        plm_pkg::OFF_FLOW_TUNE_SEL: s_nxt.rdata = {14'h0000, s_r.ftune[idx]};
        plm_pkg::OFF_DIR_SEL: s_nxt.rdata = {14'h0000, s_r.dir[idx]};
        plm_pkg::OFF_ACTIVITY: s_nxt.rdata = {14'h0000, act_code};
        plm_pkg::OFF_CFG_TYPE: s_nxt.rdata = {14'h0000, type_sel};
        plm_pkg::OFF_TASK_TYPE: s_nxt.rdata = {14'h0000, task_code};
        plm_pkg::OFF_AM_STATE: s_nxt.rdata = {14'h0000, s_r.am[idx]};
        plm_pkg::OFF_SP_STATE: s_nxt.rdata = {14'h0000, s_r.sp[idx]};
        plm_pkg::OFF_TUNE_STATE: s_nxt.rdata = {14'h0000, s_r.tune[idx]};
        plm_pkg::OFF_ERR_STATUS: s_nxt.rdata = {13'h0000, err_sel};
        plm_pkg::OFF_MAN_HI: s_nxt.rdata = s_r.man_val[idx][31:16];
        plm_pkg::OFF_MAN_LO: s_nxt.rdata = s_r.man_val[idx][15:0];
        default: s_nxt.rdata = 16'h0000;
      endcase
    end else if (reg_rd) begin
      s_nxt.rdata = 16'h0000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.am <= {8{plm_pkg::CODE_RESET}};
      s_r.sp <= {8{plm_pkg::CODE_RESET}};
      s_r.tune <= {8{plm_pkg::CODE_RESET}};
      s_r.dam <= {8{plm_pkg::CODE_RESET}};
      s_r.dsp <= {8{plm_pkg::CODE_RESET}};
      s_r.ptune <= {8{plm_pkg::CODE_RESET}};
      s_r.ftune <= {8{plm_pkg::CODE_RESET}};
      s_r.dir <= {8{plm_pkg::CODE_RESET}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign reg_ack = s_r.ack;
  assign reg_err = s_r.err;
  assign manual_out_valid = s_r.mo_valid;
  assign manual_out_data = s_r.mo_data;
  assign manual_out_loop = s_r.mo_loop;

  for (genvar g = 0; g < plm_pkg::NUM_LOOPS; g++) begin : g_loop
    assign single_manual[g] = (s_r.am[g] == plm_pkg::CODE_TWO);
    assign single_remote_setpoint[g] = (s_r.sp[g] == plm_pkg::CODE_TWO);
    assign single_second_tuning_set[g] = (s_r.tune[g] == plm_pkg::CODE_TWO);
    assign dual_manual[g] = (s_r.dam[g] == plm_pkg::CODE_TWO);
    assign dual_remote_setpoint[g] = (s_r.dsp[g] == plm_pkg::CODE_TWO);
    assign pressure_loop_second_tuning_set[g] = (s_r.ptune[g] == plm_pkg::CODE_TWO);
    assign flow_loop_second_tuning_set[g] = (s_r.ftune[g] == plm_pkg::CODE_TWO);
    assign flow_negative[g] = (s_r.dir[g] == plm_pkg::CODE_TWO);
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_low_write_new;
    reg_wr && hit && off == plm_pkg::OFF_MAN_LO && man_new != s_r.man_val[idx];
  endsequence

  sequence seq_forward;
    manual_out_valid && manual_out_data == $past(man_new) && manual_out_loop == $past(idx);
  endsequence

  a_ack_each_access: assert property (access |=> reg_ack && !$past(hit) == reg_err)
    else $error("access not acknowledged correctly");

  a_am_manual_write: assert property (
    reg_wr && hit && off == plm_pkg::OFF_AM_SEL && reg_wdata == 16'h0002
    |=> single_manual[$past(idx)])
    else $error("manual mode write not applied");

  a_bad_code_ignored: assert property (
    reg_wr && hit && off == plm_pkg::OFF_SP_SEL && !code_ok
    |=> $stable(s_r.sp))
    else $error("invalid code changed setpoint source");

  a_ro_write_ignored: assert property (
    reg_wr && hit && off >= plm_pkg::OFF_ACTIVITY && off <= plm_pkg::OFF_ERR_STATUS
    |=> $stable(s_r.am) && $stable(s_r.dir) && $stable(s_r.tune))
    else $error("read-only write changed state");

  a_dir_negative: assert property (
    reg_wr && hit && off == plm_pkg::OFF_DIR_SEL && reg_wdata == 16'h0002
    |=> flow_negative[$past(idx)])
    else $error("flow direction write not applied");

  a_type_readback: assert property (
    reg_rd && !reg_wr && hit && off == plm_pkg::OFF_CFG_TYPE
    |=> reg_rdata == {14'h0000, $past(type_sel)})
    else $error("loop type read mismatch");

  a_err_bits_read: assert property (
    reg_rd && !reg_wr && hit && off == plm_pkg::OFF_ERR_STATUS
    |=> reg_rdata == {13'h0000, $past(err_sel)})
    else $error("error status read mismatch");

  a_state_readback: assert property (
    reg_rd && !reg_wr && hit && off == plm_pkg::OFF_AM_STATE
    |=> reg_rdata == {14'h0000, s_r.am[$past(idx)]})
    else $error("mode state read mismatch");

  a_manual_fwd_new: assert property (seq_low_write_new |=> seq_forward)
    else $error("changed manual value not forwarded");

  a_manual_same_quiet: assert property (
    reg_wr && hit && off == plm_pkg::OFF_MAN_LO && man_new == s_r.man_val[idx]
    |=> !manual_out_valid)
    else $error("unchanged manual value forwarded");

  a_am_auto_write: assert property (
    wr_one && off == plm_pkg::OFF_AM_SEL
    |=> !single_manual[$past(idx)])
    else $error("auto mode write not applied");

  a_sp_remote_write: assert property (
    wr_two && off == plm_pkg::OFF_SP_SEL
    |=> single_remote_setpoint[$past(idx)])
    else $error("remote setpoint write not applied");

  a_tune_second_write: assert property (
    wr_two && off == plm_pkg::OFF_TUNE_SEL
    |=> single_second_tuning_set[$past(idx)])
    else $error("tuning set write not applied");

  a_dual_am_write: assert property (
    wr_two && off == plm_pkg::OFF_DUAL_AM_SEL
    |=> dual_manual[$past(idx)])
    else $error("dual mode write not applied");

  a_dual_sp_write: assert property (
    wr_two && off == plm_pkg::OFF_DUAL_SP_SEL
    |=> dual_remote_setpoint[$past(idx)])
    else $error("dual setpoint write not applied");

  a_press_tune_write: assert property (
    wr_two && off == plm_pkg::OFF_PRESS_TUNE_SEL
    |=> pressure_loop_second_tuning_set[$past(idx)])
    else $error("pressure tuning write not applied");

  a_flow_tune_write: assert property (
    wr_two && off == plm_pkg::OFF_FLOW_TUNE_SEL
    |=> flow_loop_second_tuning_set[$past(idx)])
    else $error("flow tuning write not applied");

  a_dir_positive_write: assert property (
    wr_one && off == plm_pkg::OFF_DIR_SEL
    |=> !flow_negative[$past(idx)])
    else $error("positive direction write not applied");

  a_sp_sel_readback: assert property (
    rd_hit && off == plm_pkg::OFF_SP_SEL
    |=> reg_rdata == {14'h0000, s_r.sp[$past(idx)]})
    else $error("setpoint selection read mismatch");

  a_tune_sel_readback: assert property (
    rd_hit && off == plm_pkg::OFF_TUNE_SEL
    |=> reg_rdata == {14'h0000, s_r.tune[$past(idx)]})
    else $error("tuning selection read mismatch");

  a_dir_sel_readback: assert property (
    rd_hit && off == plm_pkg::OFF_DIR_SEL
    |=> reg_rdata == {14'h0000, s_r.dir[$past(idx)]})
    else $error("direction selection read mismatch");

  a_activity_read: assert property (
    rd_hit && off == plm_pkg::OFF_ACTIVITY
    |=> reg_rdata == {14'h0000, $past(act_code)})
    else $error("loop activity read mismatch");

  a_task_type_read: assert property (
    rd_hit && off == plm_pkg::OFF_TASK_TYPE
    |=> reg_rdata == {14'h0000, $past(task_code)})
    else $error("dual task read mismatch");

  a_sp_state_read: assert property (
    rd_hit && off == plm_pkg::OFF_SP_STATE
    |=> reg_rdata == {14'h0000, s_r.sp[$past(idx)]})
    else $error("setpoint state read mismatch");

  a_tune_state_read: assert property (
    rd_hit && off == plm_pkg::OFF_TUNE_STATE
    |=> reg_rdata == {14'h0000, s_r.tune[$past(idx)]})
    else $error("tuning state read mismatch");

  a_idle_no_ack: assert property (
    !access
    |=> !reg_ack && !reg_err)
    else $error("acknowledge without access");

  a_outside_read_zero: assert property (
    reg_rd && !reg_wr && !hit
    |=> reg_err && reg_rdata == 16'h0000)
    else $error("unmapped read not flagged");

  a_window_gap_zero: assert property (
    rd_hit && off > plm_pkg::OFF_MAN_LO
    |=> !reg_err && reg_rdata == 16'h0000)
    else $error("unused in-window read not zero");

  a_wr_keeps_rdata: assert property (
    reg_wr
    |=> $stable(reg_rdata))
    else $error("write disturbed read data");

  a_hi_write_quiet: assert property (
    reg_wr && hit && off == plm_pkg::OFF_MAN_HI
    |=> !manual_out_valid)
    else $error("high word write forwarded");

  a_mo_data_hold: assert property (
    !manual_out_valid
    |-> $stable(manual_out_data) && $stable(manual_out_loop))
    else $error("manual output changed without pulse");

  a_bad_am_ignored: assert property (
    reg_wr && hit && off == plm_pkg::OFF_AM_SEL && !code_ok
    |=> $stable(s_r.am))
    else $error("invalid code changed mode");

  a_bad_dir_ignored: assert property (
    reg_wr && hit && off == plm_pkg::OFF_DIR_SEL && !code_ok
    |=> $stable(s_r.dir))
    else $error("invalid code changed direction");

endmodule : plm_regbank

// ===== tb/plm_master_model.sv
// Remote master model: one register access at a time.
// Assumes the bank answers each strobe on the next edge.
`timescale 1ns/100ps
module plm_master_model (
  input wire logic core_clk,
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_wdata
);
  initial begin
    {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
  end
  task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= addr;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge core_clk);
    // Released lines change, so stale values never pass
    {reg_wr, reg_rd} <= 2'h0;
    reg_addr <= ~addr;
    reg_wdata <= ~d;
  endtask : xfer
endmodule : plm_master_model

// ===== tb/tb_pid_loop_mode_register_map.sv
// Testbench for the loop mode register bank.
// Assumes plm_pkg, plm_regbank and the master model are compiled first.
`timescale 1ns/100ps
module tb_pid_loop_mode_register_map;
  logic core_clk, rst_n, reg_wr, reg_rd, reg_ack, reg_err, mo_valid;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, loop_type_code;
  logic [7:0] loop_active, task_outlet_max, pv_invalid, sp_invalid;
  logic [7:0] sel_out [8];
  logic [31:0] mo_data;
  logic [2:0] mo_loop;
  logic [1:0] code_m [9][8];
  logic [17:0] rd_q [$];
  logic [34:0] mo_q [$];
  logic [17:0] exp_n;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  integer seed = 32'hf7c6;
  plm_master_model mst_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  plm_regbank dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .loop_active(loop_active),
    .loop_type_code(loop_type_code), .task_outlet_max(task_outlet_max),
    .pv_invalid(pv_invalid), .sp_invalid(sp_invalid), .single_manual(sel_out[0]),
    .single_remote_setpoint(sel_out[1]), .single_second_tuning_set(sel_out[2]),
    .dual_manual(sel_out[3]), .dual_remote_setpoint(sel_out[4]),
    .pressure_loop_second_tuning_set(sel_out[5]),
    .flow_loop_second_tuning_set(sel_out[6]), .flow_negative(sel_out[7]),
    .manual_out_valid(mo_valid), .manual_out_data(mo_data), .manual_out_loop(mo_loop));
  task automatic bump(input logic ok, input string what);
    total_checks++;
    if (!ok) begin
      n_errors++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask : bump
  task automatic cmp_rd(input logic [16:0] got, input logic [16:0] exp);
    bump(got === exp, "register answer mismatch");
  endtask : cmp_rd
  task automatic cmp_mo(input logic [34:0] got, input logic [34:0] exp);
    bump(got === exp, "manual output mismatch");
  endtask : cmp_mo
  task automatic cmp_sel(input logic got, input logic exp);
    bump(got === exp, "decoded mode level mismatch");
  endtask : cmp_sel
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  // Expectation noted first, then the access; err always checked
  task automatic acc(input logic wr, input int lp, input int off, input logic [15:0] d,
    input logic [15:0] exp, input logic err);
    rd_q.push_back({!wr, err, exp});
    mst_u.xfer(wr, plm_pkg::ADDR_BASE + plm_pkg::LOOP_STRIDE * 16'(lp) + 16'(off), d);
  endtask : acc
  task automatic chk_sel();
    @(negedge core_clk);
    for (int o = 0; o < 8; o++)
      for (int l = 0; l < 8; l++)
        cmp_sel(sel_out[o][l], code_m[l+1][o] == plm_pkg::CODE_TWO);
  endtask : chk_sel
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      $display("ERROR %0t run timed out", $time);
      wrap_up();
    end
  end
  always @(negedge core_clk) begin
    if (reg_ack === 1'b1) begin
      if (rd_q.size() == 0)
        bump(1'b0, "unexpected acknowledge");
      else begin
        exp_n = rd_q.pop_front();
        cmp_rd({reg_err, exp_n[17] ? reg_rdata : exp_n[15:0]}, exp_n[16:0]);
      end
    end
    if (mo_valid === 1'b1) begin
      if (mo_q.size() == 0)
        bump(1'b0, "unexpected manual output");
      else
        cmp_mo({mo_loop, mo_data}, mo_q.pop_front());
    end
  end
  initial begin
    logic [31:0] w;
    logic [15:0] d;
    int lp, o;
    rst_n = 1'b0;
    {loop_active, task_outlet_max, pv_invalid, sp_invalid, loop_type_code} = '0;
    foreach (code_m[l, k]) code_m[l][k] = plm_pkg::CODE_RESET;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    for (lp = 1; lp <= 8; lp++)
      for (o = 0; o < 8; o++)
        acc(1'b0, lp, o, 16'h0000, 16'(code_m[lp][o]), 1'b0);
    chk_sel();
    repeat (120) begin
      w = $random(seed);
      lp = 1 + int'(w[18:16]);
      o = int'(w[22:20]);
      // Half small codes, half wide junk values
      d = w[4] ? 16'(w[1:0]) : w[15:0];
      acc(1'b1, lp, 11 + o % 3, 16'(2'h3 - code_m[lp][o % 3]), 16'h0000, 1'b0);
      acc(1'b1, lp, o, d, 16'h0000, 1'b0);
      if (d == 16'h0001 || d == 16'h0002)
        code_m[lp][o] = d[1:0];
      acc(1'b0, lp, o, 16'h0000, 16'(code_m[lp][o]), 1'b0);
      acc(1'b0, lp, 11 + o % 3, 16'h0000, 16'(code_m[lp][o % 3]), 1'b0);
      chk_sel();
    end
    repeat (3) begin
      @(posedge core_clk);
      loop_active <= 8'($random(seed));
      task_outlet_max <= 8'($random(seed));
      loop_type_code <= 16'($random(seed));
      pv_invalid <= 8'($random(seed));
      sp_invalid <= 8'($random(seed));
      @(posedge core_clk);
      for (lp = 1; lp <= 8; lp++) begin
        acc(1'b0, lp, 8, 16'h0000, loop_active[lp - 1] ? 16'h0001 : 16'h0002, 1'b0);
        acc(1'b0, lp, 9, 16'h0000, 16'(loop_type_code[2 * lp - 1 -: 2]), 1'b0);
        acc(1'b0, lp, 10, 16'h0000, task_outlet_max[lp - 1] ? 16'h0001 : 16'h0002, 1'b0);
        d = {13'h0000, sp_invalid[lp-1], pv_invalid[lp-1], !(pv_invalid[lp-1] | sp_invalid[lp-1])};
        acc(1'b0, lp, 14, 16'h0000, d, 1'b0);
      end
    end
    for (lp = 1; lp <= 8; lp++) begin
      w = $random(seed);
      acc(1'b1, lp, 24, w[31:16], 16'h0000, 1'b0);
      if (w != 32'h0000_0000)
        mo_q.push_back({3'(lp - 1), w});
      acc(1'b1, lp, 25, w[15:0], 16'h0000, 1'b0);
      acc(1'b1, lp, 25, w[15:0], 16'h0000, 1'b0);
      acc(1'b0, lp, 24, 16'h0000, w[31:16], 1'b0);
    end
    acc(1'b0, 0, 0, 16'h0000, 16'h0000, 1'b1);
    acc(1'b1, 9, 0, 16'h0002, 16'h0000, 1'b1);
    acc(1'b0, 1, 50, 16'h0000, 16'h0000, 1'b0);
    chk_sel();
    repeat (3) @(negedge core_clk);
    bump(rd_q.size() == 0 && mo_q.size() == 0, "missing answer");
    wrap_up();
  end
endmodule : tb_pid_loop_mode_register_map
